/* File: qawae_defs.vh */
// constants for the q&a watchdog answer evaluator
`ifndef QAWAE_DEFS_VH
`define QAWAE_DEFS_VH
// register byte addresses
`define QAWAE_ADDR_CTRL 12'h0000
`define QAWAE_ADDR_QUESTION 12'h0004
`define QAWAE_ADDR_ANSWER 12'h0008
`define QAWAE_ADDR_STATUS 12'h000C
`define QAWAE_ADDR_MASK 12'h0010
`define QAWAE_ADDR_EXPECT 12'h0014
// ctrl fields
`define QAWAE_CTRL_MODE_BIT 0
`define QAWAE_CTRL_LIMIT_LSB 4
`define QAWAE_CTRL_LIMIT_MSB 7
// status / mask fields
`define QAWAE_ST_ANSW_ERR 0
`define QAWAE_ST_WATCHDOG_ERROR_FLAG 1
`define QAWAE_ST_CYCLE_DONE 2
`define QAWAE_ST_LIMIT 3
`define QAWAE_ST_WIDTH 4
// reset values
`define QAWAE_CTRL_RESET 32'h0000_00F0
`define QAWAE_MASK_RESET 4'h0
`define QAWAE_LIMIT_RESET 4'hF
`define QAWAE_MODE_MULTI 1'b0
// window phases
`define QAWAE_PHASE_W1 1'b0
`define QAWAE_PHASE_W2 1'b1
`endif

/* File: qawae_evaluator.v */
// q&a watchdog multi-answer evaluator with ahb-lite register slave
// What this block does
// - multi-answer evaluation runs only when answer mode select is zero
// - three correct then one correct: new cycle, decrement failures, new question
// - under four answers by window two end: restart, increment, same question, error
// - incomplete cycle with only correct answers: watchdog error only
// - incomplete cycle with three wrong window-one answers: both error flags
// - four answers with any wrong: restart, increment, same question, both flags
// - four answers in window one: failure, answer error only if wrong
// - two-bit answer counter separates complete from incomplete cycles
// - watchdog error flag is the or of all watchdog error conditions
// - failure counter reaching limit triggers the watchdog action
`timescale 1ns/1ps
`default_nettype none
`include "qawae_defs.vh"
module qawae_evaluator #(
  parameter FAIL_WIDTH = 4
) (
  input wire clock_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire window_phase_in,
  input wire window2_end_in,
  input wire [31:0] expected_answers_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  output reg new_question_out,
  output reg [FAIL_WIDTH-1:0] failure_count_out,
  output reg watchdog_action_out,
  output reg irq_out
);
  // synchronised window inputs (they come from the timer, treated as foreign)
  // two cycles of lag only move the window edge, answers arrive far slower
  reg phase_s1;
  reg phase_s2;
  reg w2end_s1;
  reg w2end_s2;
  reg w2end_s3;
  // bus address phase capture
  // write data follows its address by one cycle, so the address is kept
  reg wr_pend;
  reg [11:0] wr_addr;
  // registers
  reg answer_mode_select;
  reg [3:0] fail_limit;
  reg [7:0] question_register;
  reg [3:0] irq_mask;
  reg [3:0] irq_status;
  reg answer_error_flag;
  reg watchdog_error_flag;
  // cycle state, cleared at every cycle end whatever the outcome
  reg [1:0] answer_counter;
  reg wrong_seen;
  reg [1:0] w1_count;
  reg w2_seen;
  // decode and evaluation terms
  wire addr_phase;
  wire w2end_pulse;
  wire ans_wr;
  wire [7:0] ans_byte;
  wire [7:0] exp_byte;
  wire ans_ok;
  wire fourth;
  wire wrong_total;
  wire all_w1;
  wire good_seq;
  wire cycle_end;
  wire fail_event;
  wire limit_hit;
  wire [3:0] status_evt;
  reg [31:0] next_rdata;

  // a transfer is taken only while the bus is ready; hsize_in is not decoded
  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign w2end_pulse = w2end_s2 & ~w2end_s3;
  assign ans_wr = wr_pend & (wr_addr == `QAWAE_ADDR_ANSWER);
  assign ans_byte = hwdata_in[7:0];

  // expected byte picked by position
  // the first answer of a cycle is checked against the top byte
  assign exp_byte = expected_answers_in[{~answer_counter, 3'b000} +: 8];
  assign ans_ok = (ans_byte == exp_byte);

  // counter value three plus a write makes the fourth answer
  assign fourth = ans_wr & (answer_mode_select == `QAWAE_MODE_MULTI) & (answer_counter == 2'd3);
  // the fourth byte is judged in the cycle that closes the evaluation
  assign wrong_total = wrong_seen | ~ans_ok;
  // all four in window one means the fourth landed before window two
  assign all_w1 = (phase_s2 == `QAWAE_PHASE_W1);
  // three in window one then one in window two, all correct
  assign good_seq = fourth & ~wrong_total & ~all_w1 & (w1_count == 2'd3) & ~w2_seen;
  // the fourth answer, or window two ending before it, closes the cycle
  assign cycle_end = fourth |
    (w2end_pulse & (answer_mode_select == `QAWAE_MODE_MULTI) & ~fourth);
  // any cycle end other than the good sequence is a failure
  assign fail_event = cycle_end & ~good_seq;
  // limit reached on this failure
  // the count after this failure is compared: the action comes on the limit-th failure
  assign limit_hit = fail_event & (failure_count_out + 1'b1 >= fail_limit);
  // status events: limit, cycle end, watchdog error, answer error
  assign status_evt = {limit_hit, cycle_end,
    fail_event, fail_event & (fourth ? wrong_total : wrong_seen)};

  // input synchronisers, first stage read only by the second
  // w2end_s3 only delays the second stage to find its rising edge
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      phase_s1 <= 1'b0;
      phase_s2 <= 1'b0;
      w2end_s1 <= 1'b0;
      w2end_s2 <= 1'b0;
      w2end_s3 <= 1'b0;
    end
    else
    begin
      phase_s1 <= window_phase_in;
      phase_s2 <= phase_s1;
      w2end_s1 <= window2_end_in;
      w2end_s2 <= w2end_s1;
      w2end_s3 <= w2end_s2;
    end
  end

  // ahb-lite: zero wait states, always okay, write data in data phase
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      // address kept every cycle; only wr_pend decides whether it is used
      wr_pend <= addr_phase & hwrite_in;
      wr_addr <= haddr_in[11:0];
      if (addr_phase & ~hwrite_in)
        hrdata_out <= next_rdata;
    end
  end

  // read mux, unmapped reads as zero
  // read data shows the state at the address edge
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_in[11:0])
      `QAWAE_ADDR_CTRL:
        next_rdata = {24'h00_0000, fail_limit, 3'b000, answer_mode_select};
      `QAWAE_ADDR_QUESTION:
        next_rdata = {12'h000, failure_count_out, 2'b00, answer_counter,
          2'b00, watchdog_error_flag, answer_error_flag, question_register};
      `QAWAE_ADDR_STATUS:
        next_rdata = {28'h000_0000, irq_status};
      `QAWAE_ADDR_MASK:
        next_rdata = {28'h000_0000, irq_mask};
      `QAWAE_ADDR_EXPECT:
        next_rdata = expected_answers_in;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // software configuration registers
  // mode and limit may change mid-cycle; the next answer sees the new mode
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      answer_mode_select <= `QAWAE_MODE_MULTI;
      fail_limit <= `QAWAE_LIMIT_RESET;
      irq_mask <= `QAWAE_MASK_RESET;
    end
    else if (wr_pend)
    begin
      if (wr_addr == `QAWAE_ADDR_CTRL)
      begin
        answer_mode_select <= hwdata_in[`QAWAE_CTRL_MODE_BIT];
        fail_limit <= hwdata_in[`QAWAE_CTRL_LIMIT_MSB:`QAWAE_CTRL_LIMIT_LSB];
      end
      if (wr_addr == `QAWAE_ADDR_MASK)
        irq_mask <= hwdata_in[`QAWAE_ST_WIDTH-1:0];
    end
  end

  // sticky interrupt status, set beats write-one-to-clear
  // an event in the same cycle as its clear stays set, so none is lost
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      irq_status <= 4'h0;
    else if (wr_pend & (wr_addr == `QAWAE_ADDR_STATUS))
      irq_status <= (irq_status & ~hwdata_in[3:0]) | status_evt;
    else
      irq_status <= irq_status | status_evt;
  end

  // interrupt output registered
  // one cycle of lag keeps the pin driven straight from a flop
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status & irq_mask);
  end

  // per-cycle answer tracking
  // the window of each answer is the synchronised phase at its data edge
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      answer_counter <= 2'd0;
      wrong_seen <= 1'b0;
      w1_count <= 2'd0;
      w2_seen <= 1'b0;
    end
    else if (cycle_end)
    begin
      answer_counter <= 2'd0;
      wrong_seen <= 1'b0;
      w1_count <= 2'd0;
      w2_seen <= 1'b0;
    end
    // writes while single-answer evaluation is selected are not counted
    else if (ans_wr & (answer_mode_select == `QAWAE_MODE_MULTI))
    begin
      answer_counter <= answer_counter + 2'd1;
      wrong_seen <= wrong_seen | ~ans_ok;
      if (phase_s2 == `QAWAE_PHASE_W1)
      begin
        // a fourth window-one answer closes the cycle, so three is the top
        if (w1_count != 2'd3)
          w1_count <= w1_count + 2'd1;
      end
      else
        w2_seen <= 1'b1;
    end
  end

  // cycle outcome: flags, failure counter, question renewal
  // the question is a plain counter here; the real generator sits outside
  always @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      answer_error_flag <= 1'b0;
      watchdog_error_flag <= 1'b0;
      failure_count_out <= {FAIL_WIDTH{1'b0}};
      new_question_out <= 1'b0;
      watchdog_action_out <= 1'b0;
      question_register <= 8'h00;
    end
    else
    begin
      // both pulses last exactly one cycle
      new_question_out <= good_seq;
      watchdog_action_out <= limit_hit;
      if (good_seq)
      begin
        answer_error_flag <= 1'b0;
        watchdog_error_flag <= 1'b0;
        question_register <= question_register + 8'h01;
        // the counter rests at zero instead of wrapping
        if (failure_count_out != {FAIL_WIDTH{1'b0}})
          failure_count_out <= failure_count_out - 1'b1;
      end
      else if (fail_event)
      begin
        // answer error only when a byte was wrong
        answer_error_flag <= fourth ? wrong_total : wrong_seen;
        // any failure raises the summary flag
        watchdog_error_flag <= 1'b1;
        // failure counter up, question kept
        // after the action the count starts over from zero
        if (limit_hit)
          failure_count_out <= {FAIL_WIDTH{1'b0}};
        else
          failure_count_out <= failure_count_out + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: qawae_chk.sv */
// port assertions for the answer evaluator
`timescale 1ns/1ps
`default_nettype none
module qawae_chk #(
  parameter FAIL_WIDTH = 4
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic new_question_out,
  input wire logic [FAIL_WIDTH-1:0] failure_count_out,
  input wire logic watchdog_action_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // zero-wait slave, always okay
  chk_ready_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave stalled or errored");
  chk_newq_decr: assert property (new_question_out |-> failure_count_out ==
    ($past(failure_count_out) == '0 ? '0 : $past(failure_count_out) - 1'b1))
    else $error("good cycle did not step failures down");
  chk_count_step: assert property ($changed(failure_count_out) |->
    watchdog_action_out || failure_count_out == $past(failure_count_out) + 1'b1
    || failure_count_out == $past(failure_count_out) - 1'b1)
    else $error("failure count jumped");
  chk_up_keepq: assert property ($changed(failure_count_out) &&
    failure_count_out == $past(failure_count_out) + 1'b1 |-> !new_question_out)
    else $error("failed cycle renewed the question");
  chk_act_zero: assert property (watchdog_action_out |-> failure_count_out == '0)
    else $error("count not cleared on action");
  chk_act_pulse: assert property (watchdog_action_out |=> !watchdog_action_out)
    else $error("action longer than one cycle");
  chk_newq_pulse: assert property (new_question_out |=> !new_question_out)
    else $error("new question longer than one cycle");
  chk_no_both: assert property (!(new_question_out && watchdog_action_out))
    else $error("action on a good cycle");
  // main scenarios reached
  cov_newq: cover property (new_question_out);
  cov_act: cover property (watchdog_action_out);
  cov_irq: cover property (irq_out);
endmodule
bind qawae_evaluator qawae_chk #(.FAIL_WIDTH(FAIL_WIDTH)) chk (.clock_in(clock_in),
  .reset_in(reset_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .new_question_out(new_question_out), .failure_count_out(failure_count_out),
  .watchdog_action_out(watchdog_action_out), .irq_out(irq_out));
`default_nettype wire

/* File: qawae_host.sv */
// host model issuing single ahb-lite transfers
`timescale 1ns/1ps
`default_nettype none
module qawae_host (
  input wire logic clock_in,
  input wire logic ready_in,
  input wire logic [31:0] rdata_in,
  output logic sel_out,
  output logic [31:0] addr_out,
  output logic [1:0] trans_out,
  output logic write_out,
  output logic [31:0] wdata_out
);
  // bus idle at time zero
  initial
    {sel_out, addr_out, trans_out, write_out, wdata_out} = '0;
  // each phase held until ready; data line scrambled after use
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clock_in);
    sel_out <= 1'b1;
    trans_out <= 2'b10;
    addr_out <= a;
    write_out <= w;
    do @(posedge clock_in); while (ready_in !== 1'b1);
    trans_out <= 2'b00;
    wdata_out <= d;
    do @(posedge clock_in); while (ready_in !== 1'b1);
    r = rdata_in;
    wdata_out <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the answer evaluator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic sel, wr, rdy, newq, act, irq;
  logic phase = 1'b0;
  logic w2end = 1'b0;
  logic [1:0] trans;
  logic [3:0] fails;
  logic [3:0] m_fc = 4'h0;
  logic [31:0] addr, wdata, rdata, r;
  logic [31:0] ea = '0;
  logic [31:0] seed = 32'hde87_f287;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int nq_cnt = 0;
  int act_cnt = 0;
  int i;
  int t1[11] = '{3, 2, 1, 3, 3, 3, 3, 4, 4, 4, 4};
  int t2[11] = '{1, 0, 0, 1, 0, 1, 1, 0, 0, 0, 0};
  logic [3:0] bad_tab[11] = '{0, 0, 0, 8, 7, 7, 15, 0, 8, 12, 14};
  qawae_host host (.clock_in(clock_in), .ready_in(rdy), .rdata_in(rdata), .sel_out(sel),
    .addr_out(addr), .trans_out(trans), .write_out(wr), .wdata_out(wdata));
  qawae_evaluator #(.FAIL_WIDTH(4)) dut (.clock_in(clock_in), .reset_in(reset_in),
    .hsel_in(sel), .haddr_in(addr), .htrans_in(trans), .hwrite_in(wr), .hsize_in(3'b010),
    .hwdata_in(wdata), .hready_in(rdy), .window_phase_in(phase), .window2_end_in(w2end),
    .expected_answers_in(ea), .hrdata_out(rdata), .hreadyout_out(rdy), .hresp_out(),
    .new_question_out(newq), .failure_count_out(fails), .watchdog_action_out(act),
    .irq_out(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // limit of four: a failure that reaches it clears the count
  function automatic logic [3:0] next_fc(input logic [3:0] f, input logic ok);
    if (ok)
      return (f == 4'h0) ? f : f - 4'h1;
    return (f >= 4'h3) ? 4'h0 : f + 4'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one watchdog cycle: n1 answers in window one, n2 in window two
  task automatic scen(input int n1, input int n2, input logic [3:0] bad);
    logic [7:0] q;
    logic ok, ae;
    int n;
    int nq0, a0;
    logic exp_act;
    @(posedge clock_in);
    nq0 = nq_cnt;
    a0 = act_cnt;
    seed = lfsr(seed);
    ea <= seed;
    phase <= 1'b0;
    repeat (3) @(posedge clock_in);
    host.xfer(1'b0, 32'h0000_0004, '0, r);
    q = r[7:0];
    for (n = 0; n < n1 + n2; n++)
    begin
      if (n == n1)
      begin
        phase <= 1'b1;
        repeat (3) @(posedge clock_in);
      end
      host.xfer(1'b1, 32'h0000_0008, {24'h00_0000, ea[31-8*n -: 8] ^ {8{bad[n]}}}, r);
    end
    // a short cycle only closes with window two
    if (n1 + n2 < 4)
    begin
      phase <= 1'b1;
      repeat (3) @(posedge clock_in);
      w2end <= 1'b1;
      repeat (3) @(posedge clock_in);
      w2end <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    ok = (n1 == 3) && (n2 == 1) && (bad == 4'h0);
    ae = |(bad & ~(4'hF << (n1 + n2)));
    exp_act = ~ok && (m_fc >= 4'h3);
    m_fc = next_fc(m_fc, ok);
    host.xfer(1'b0, 32'h0000_0004, '0, r);
    chk(r[7:0], {q + {7'h00, ok}});
    chk(r[9:8], {~ok, ae});
    chk({r[19:16], fails}, {m_fc, m_fc});
    chk(r[13:12], 2'b00);
    chk(nq_cnt - nq0, ok);
    chk(act_cnt - a0, exp_act);
    $display("scenario %0d+%0d bad %h done", n1, n2, bad);
  endtask
  initial
    forever #25 clock_in = ~clock_in;
  // hang guard
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (newq === 1'b1)
      nq_cnt <= nq_cnt + 1;
    if (act === 1'b1)
      act_cnt <= act_cnt + 1;
    if (cyc == 30000)
    begin
      err_count++;
      give_verdict();
    end
  end
  // main sequence: registers, mode, tabled cases, random cases, interrupt
  initial
  begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    host.xfer(1'b0, 32'h0000_0000, '0, r);
    chk(r, 32'h0000_00F0);
    host.xfer(1'b0, 32'h0000_0020, '0, r);
    chk(r, '0);
    host.xfer(1'b1, 32'h0000_0000, 32'h0000_0041, r);
    host.xfer(1'b1, 32'h0000_0008, '0, r);
    host.xfer(1'b0, 32'h0000_0004, '0, r);
    chk(r[13:12], 2'b00);
    host.xfer(1'b1, 32'h0000_0000, 32'h0000_0040, r);
    for (i = 0; i < 11; i++)
      scen(t1[i], t2[i], bad_tab[i]);
    for (i = 0; i < 8; i++)
      scen(1 + seed[1:0], seed[1:0] == 2'b11 ? 0 : seed[2], seed[7:4] & {4{seed[3]}});
    scen(0, 0, 4'h0);
    host.xfer(1'b1, 32'h0000_0010, 32'h0000_0003, r);
    host.xfer(1'b1, 32'h0000_000C, 32'h0000_000F, r);
    repeat (2) @(posedge clock_in);
    chk(irq, 1'b0);
    scen(2, 0, 4'h0);
    chk(irq, 1'b1);
    host.xfer(1'b1, 32'h0000_000C, 32'h0000_000F, r);
    repeat (2) @(posedge clock_in);
    chk(irq, 1'b0);
    reset_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    host.xfer(1'b0, 32'h0000_0000, '0, r);
    chk(r, 32'h0000_00F0);
    host.xfer(1'b0, 32'h0000_0004, '0, r);
    chk(r, '0);
    give_verdict();
  end
endmodule
`default_nettype wire
